/* design/ies_pkg.sv */
// Register map, field positions and reset values of the request block
package ies_pkg;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned DATA_W = 8;
  // Register offsets
  localparam logic [5:0] COM_EN_OFF  = 6'h02;
  localparam logic [5:0] AUX_EN_OFF  = 6'h03;
  localparam logic [5:0] COM_REQ_OFF = 6'h04;
  localparam logic [5:0] AUX_REQ_OFF = 6'h05;
  localparam logic [5:0] ERR_OFF     = 6'h06;
  localparam logic [5:0] STAT_OFF    = 6'h07;
  // Reset values
  localparam logic [7:0] COM_EN_RST  = 8'h80;
  localparam logic [7:0] AUX_EN_RST  = 8'h00;
  localparam logic [7:0] COM_REQ_RST = 8'h14;
  localparam logic [7:0] AUX_REQ_RST = 8'h00;
  localparam logic [7:0] ERR_RST     = 8'h00;
  // Implemented bits
  localparam logic [7:0] COM_REQ_MSK = 8'h7f;
  localparam logic [7:0] AUX_REQ_MSK = 8'h14;
  localparam logic [7:0] ERR_MSK     = 8'hdf;
  localparam logic [7:0] EN_AUX_MSK  = 8'h14;
  // Common request and enable register fields
  localparam int unsigned SET_SEL_BIT = 7;
  localparam int unsigned TX_BIT      = 6;
  localparam int unsigned RX_BIT      = 5;
  localparam int unsigned IDLE_BIT    = 4;
  localparam int unsigned HI_BIT      = 3;
  localparam int unsigned LO_BIT      = 2;
  localparam int unsigned ERRS_BIT    = 1;
  localparam int unsigned TMR_BIT     = 0;
  localparam int unsigned INV_BIT     = 7;
  // Auxiliary request register fields
  localparam int unsigned EXT_BIT     = 4;
  localparam int unsigned CRCD_BIT    = 2;
  // Error register fields
  localparam int unsigned WR_ERR_BIT  = 7;
  localparam int unsigned TEMP_BIT    = 6;
  localparam int unsigned OVF_BIT     = 4;
  localparam int unsigned COLL_BIT    = 3;
  localparam int unsigned CRCE_BIT    = 2;
  localparam int unsigned PAR_BIT     = 1;
  localparam int unsigned FRM_BIT     = 0;
  localparam logic [7:0] RX_CLR_MSK   = 8'h0f;
  localparam logic [7:0] CMD_CLR_MSK  = 8'hbf;
  // Status register fields
  localparam int unsigned ST_IRQ_BIT  = 4;
  localparam int unsigned ST_HI_BIT   = 1;
  localparam int unsigned ST_LO_BIT   = 0;
endpackage

/* design/ies_sync.sv */
// Two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module ies_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // Level
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule
`default_nettype wire

/* design/ies_req_bits.sv */
// Sticky flag register where a hardware set beats a clear
`timescale 1ns/1ps
`default_nettype none
module ies_req_bits #(
  parameter logic [7:0] RST = 8'h00,
  parameter logic [7:0] MSK = 8'hff
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  // Set and clear masks
  input  wire logic [7:0] hw_set_i,
  input  wire logic [7:0] sw_set_i,
  input  wire logic [7:0] clr_i,
  output logic      [7:0] flags_o
);
  // Set terms are OR-ed after the clear so no event is lost
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flags_o <= RST;
    end else begin
      flags_o <= ((flags_o & ~clr_i) | sw_set_i | hw_set_i) & MSK;
    end
  end
endmodule
`default_nettype wire

/* design/ies_status.sv */
// Interrupt request latching, error status and interrupt pin
// Summary of operation
// - Common write sets or clears marked bits
// - Aux write sets or clears marked bits
// - Transmit done after final bit sent
// - Receive done at valid end, optionally nonempty
// - Idle on command end or unknown command
// - Host idle write raises no idle
// - Latch high watermark rise until cleared
// - Latch low watermark rise until cleared
// - Error summary while any error set
// - Timer request when count reaches zero
// - Edge on card link input sets request
// - CRC done when calculation finishes
// - FIFO host write misuse error
// - Overheat error switches antenna off
// - Overflow on write into full FIFO
// - Collision only at 106 kBd
// - CRC error when checking enabled
// - Parity error only at 106 kBd
// - Framing error on bad start or count, only at 106 kBd
// - Command start clears errors except overheat
// - Host cannot set error bits
// - Enable gates each request
// - Summary status of enabled requests
// - Pin equal or inverted by control bit
`timescale 1ns/1ps
`default_nettype none
module ies_status
  import ies_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  // Register port
  input  wire logic [5:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  // Command sequencer
  input  wire logic        cmd_start_i,
  input  wire logic        cmd_end_i,
  input  wire logic        cmd_unknown_i,
  input  wire logic        host_idle_write_i,
  input  wire logic        crc_calculate_command_i,
  input  wire logic        card_authenticate_command_i,
  // Transmitter and receiver
  input  wire logic        tx_last_bit_i,
  input  wire logic        rx_last_bit_i,
  input  wire logic        rx_end_valid_i,
  input  wire logic        rx_startup_i,
  input  wire logic        receive_suppress_empty_i,
  input  wire logic        receive_crc_check_enable_i,
  input  wire logic        rate_106k_i,
  input  wire logic        collision_i,
  input  wire logic        crc_fail_i,
  input  wire logic        parity_fail_i,
  input  wire logic        sof_bad_i,
  input  wire logic        byte_count_bad_i,
  // FIFO, timer and CRC unit
  input  wire logic        fifo_not_empty_i,
  input  wire logic        fifo_full_i,
  input  wire logic        fifo_host_write_i,
  input  wire logic        fifo_write_i,
  input  wire logic        high_watermark_status_i,
  input  wire logic        low_watermark_status_i,
  input  wire logic        timer_zero_i,
  input  wire logic        crc_calc_done_i,
  // Pins and sensor
  input  wire logic        card_link_input_i,
  input  wire logic        overheat_i,
  input  wire logic        temp_clear_i,
  output logic             antenna_off_o,
  output logic             irq_o
);
  logic [7:0] com_en;
  logic [7:0] aux_en;
  logic [7:0] common_irq_request;
  logic [7:0] aux_irq_request;
  logic [7:0] error_status;
  logic       link_s;
  logic       link_q;
  logic       hot_s;
  logic       hi_q;
  logic       lo_q;
  logic       rf_gap;
  logic       irq_pending;
  logic       next_summary;
  logic [7:0] com_hw;
  logic [7:0] com_sw_set;
  logic [7:0] com_clr;
  logic [7:0] aux_hw;
  logic [7:0] aux_sw_set;
  logic [7:0] aux_clr;
  logic [7:0] err_hw;
  logic [7:0] err_clr;
  logic       wr_com;
  logic       wr_aux;

  function automatic logic hit(input logic [5:0] a,
                               input logic [5:0] off);
    hit = (a == off);
  endfunction

  // Pin-side levels are resynchronised before any use
  ies_sync u_link_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (card_link_input_i),
    .sync_o  (link_s)
  );

  ies_sync u_hot_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (overheat_i),
    .sync_o  (hot_s)
  );

  // Edge history for watermark and link detection
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      link_q <= 1'b0;
      hi_q   <= 1'b0;
      lo_q   <= 1'b0;
    end else begin
      link_q <= link_s;
      hi_q   <= high_watermark_status_i;
      lo_q   <= low_watermark_status_i;
    end
  end

  // Window between last sent and last received RF bit
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rf_gap <= 1'b0;
    end else if (tx_last_bit_i) begin
      rf_gap <= 1'b1;
    end else if (rx_last_bit_i || cmd_start_i) begin
      rf_gap <= 1'b0;
    end
  end

  // Enable registers
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      com_en <= COM_EN_RST;
      aux_en <= AUX_EN_RST;
    end else if (wr_i) begin
      if (hit(addr_i, COM_EN_OFF)) begin
        com_en <= wdata_i;
      end
      if (hit(addr_i, AUX_EN_OFF)) begin
        aux_en <= wdata_i & EN_AUX_MSK;
      end
    end
  end

  assign wr_com = wr_i && hit(addr_i, COM_REQ_OFF);
  assign wr_aux = wr_i && hit(addr_i, AUX_REQ_OFF);

  // Host set or clear through the set-select bit
  always_comb begin
    com_sw_set = 8'h00;
    com_clr    = 8'h00;
    aux_sw_set = 8'h00;
    aux_clr    = 8'h00;
    if (wr_com) begin
      if (wdata_i[SET_SEL_BIT]) begin
        com_sw_set = wdata_i & COM_REQ_MSK;
      end else begin
        com_clr = wdata_i & COM_REQ_MSK;
      end
    end
    if (wr_aux) begin
      if (wdata_i[SET_SEL_BIT]) begin
        aux_sw_set = wdata_i & AUX_REQ_MSK;
      end else begin
        aux_clr = wdata_i & AUX_REQ_MSK;
      end
    end
  end

  // Hardware events of the common request register
  always_comb begin
    com_hw           = 8'h00;
    com_hw[TX_BIT]   = tx_last_bit_i;
    com_hw[RX_BIT]   = rx_end_valid_i &&
                       (!receive_suppress_empty_i ||
                        fifo_not_empty_i);
    com_hw[IDLE_BIT] = (cmd_end_i && !host_idle_write_i) ||
                       cmd_unknown_i;
    com_hw[HI_BIT]   = high_watermark_status_i && !hi_q;
    com_hw[LO_BIT]   = low_watermark_status_i && !lo_q;
    com_hw[ERRS_BIT] = |error_status;
    com_hw[TMR_BIT]  = timer_zero_i;
  end

  // Hardware events of the auxiliary request register
  always_comb begin
    aux_hw           = 8'h00;
    aux_hw[EXT_BIT]  = link_s ^ link_q;
    aux_hw[CRCD_BIT] = crc_calculate_command_i && crc_calc_done_i;
  end

  // Error detection; the register port has no write path here
  always_comb begin
    err_hw             = 8'h00;
    err_hw[WR_ERR_BIT] = fifo_host_write_i &&
                         (card_authenticate_command_i || rf_gap);
    err_hw[TEMP_BIT]   = hot_s;
    err_hw[OVF_BIT]    = fifo_write_i && fifo_full_i;
    err_hw[COLL_BIT]   = collision_i && rate_106k_i;
    err_hw[CRCE_BIT]   = receive_crc_check_enable_i && crc_fail_i;
    err_hw[PAR_BIT]    = parity_fail_i && rate_106k_i;
    err_hw[FRM_BIT]    = rate_106k_i && (sof_bad_i ||
                         (card_authenticate_command_i &&
                          byte_count_bad_i));
  end

  // Clearing sources of the error register
  always_comb begin
    err_clr = 8'h00;
    if (cmd_start_i) begin
      err_clr = err_clr | CMD_CLR_MSK;
    end
    if (rx_startup_i) begin
      err_clr = err_clr | RX_CLR_MSK;
    end
    if (!rate_106k_i) begin
      err_clr[COLL_BIT] = 1'b1;
    end
    // Overheat stays latched until the sensor has cooled
    if (temp_clear_i && !hot_s) begin
      err_clr[TEMP_BIT] = 1'b1;
    end
  end

  ies_req_bits #(
    .RST (COM_REQ_RST),
    .MSK (COM_REQ_MSK)
  ) u_com_req (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .hw_set_i (com_hw),
    .sw_set_i (com_sw_set),
    .clr_i    (com_clr),
    .flags_o  (common_irq_request)
  );

  ies_req_bits #(
    .RST (AUX_REQ_RST),
    .MSK (AUX_REQ_MSK)
  ) u_aux_req (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .hw_set_i (aux_hw),
    .sw_set_i (aux_sw_set),
    .clr_i    (aux_clr),
    .flags_o  (aux_irq_request)
  );

  ies_req_bits #(
    .RST (ERR_RST),
    .MSK (ERR_MSK)
  ) u_err (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .hw_set_i (err_hw),
    .sw_set_i (8'h00),
    .clr_i    (err_clr),
    .flags_o  (error_status)
  );

  assign next_summary =
    (|(common_irq_request & com_en & COM_REQ_MSK)) ||
    (|(aux_irq_request & aux_en));

  // Pin and status follow the summary with one register stage
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_pending <= 1'b0;
      irq_o       <= 1'b0;
    end else begin
      irq_pending <= next_summary;
      irq_o       <= next_summary ^ com_en[INV_BIT];
    end
  end

  // Drivers stay off as long as the overheat flag is latched
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      antenna_off_o <= 1'b0;
    end else begin
      antenna_off_o <= error_status[TEMP_BIT];
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (!rd_i) begin
      rdata_o <= 8'h00;
    end else begin
      case (addr_i)
        COM_EN_OFF:  rdata_o <= com_en;
        AUX_EN_OFF:  rdata_o <= aux_en;
        COM_REQ_OFF: rdata_o <= common_irq_request;
        AUX_REQ_OFF: rdata_o <= aux_irq_request;
        ERR_OFF:     rdata_o <= error_status;
        STAT_OFF: begin
          rdata_o             <= 8'h00;
          rdata_o[ST_IRQ_BIT] <= irq_pending;
          rdata_o[ST_HI_BIT]  <= high_watermark_status_i;
          rdata_o[ST_LO_BIT]  <= low_watermark_status_i;
        end
        default:     rdata_o <= 8'h00;
      endcase
    end
  end

  a_com_write: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_com && !wdata_i[SET_SEL_BIT] && wdata_i[TMR_BIT] && !timer_zero_i
    |=> !common_irq_request[TMR_BIT])
    else $error("common clear left timer request set");

  a_aux_write: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_aux && wdata_i[SET_SEL_BIT] && wdata_i[CRCD_BIT]
    |=> aux_irq_request[CRCD_BIT])
    else $error("aux set did not set crc request");

  a_tx_done: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    tx_last_bit_i |=> common_irq_request[TX_BIT])
    else $error("transmit done not raised");

  a_rx_suppress: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !common_irq_request[RX_BIT] && rx_end_valid_i &&
    receive_suppress_empty_i && !fifo_not_empty_i && !wr_com
    |=> !common_irq_request[RX_BIT])
    else $error("receive done raised with empty fifo");

  a_idle_host: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !common_irq_request[IDLE_BIT] && host_idle_write_i &&
    !cmd_unknown_i && !wr_com
    |=> !common_irq_request[IDLE_BIT])
    else $error("host idle write raised idle request");

  a_err_summary: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (|error_status) |=> common_irq_request[ERRS_BIT])
    else $error("error summary missing");

  a_link_edge: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    $changed(link_s) |=> aux_irq_request[EXT_BIT])
    else $error("link edge request missing");

  a_cmd_clear: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    cmd_start_i && ((err_hw & CMD_CLR_MSK) == 8'h00)
    |=> (error_status & CMD_CLR_MSK) == 8'h00)
    else $error("command start left errors set");

  a_coll_rate: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    !rate_106k_i |=> !error_status[COLL_BIT])
    else $error("collision flag set off 106 kBd");

  a_irq_pin: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    (|(common_irq_request & com_en & COM_REQ_MSK)) && !com_en[INV_BIT]
    |=> irq_o)
    else $error("irq pin low with enabled request");

  a_hot_antenna: assert property (
    @(posedge clk_i) disable iff (!rst_b_i)
    hot_s |=> error_status[TEMP_BIT] ##1 antenna_off_o)
    else $error("overheat did not switch antenna off");
endmodule
`default_nettype wire

/* dv/ies_host_model.sv */
// Host processor model that reads and clears the request registers
`timescale 1ns/1ps
`default_nettype none
module ies_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic      [5:0] addr_o,
  output logic      [7:0] wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    addr_o = 6'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Entered just after a rising edge; the idle cycle at the end keeps
  // a strobe from being assigned twice in one time step
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    // Data stand only in this cycle; take them at the edge that ends it
    @(posedge clk_i);
    d = rdata_i;
  endtask
  task automatic set_bits(input logic [5:0] a, input logic [7:0] m);
    wr(a, 8'h80 | m);
  endtask
  task automatic clr_bits(input logic [5:0] a, input logic [7:0] m);
    wr(a, m & 8'h7f);
  endtask
endmodule
`default_nettype wire

/* dv/ies_status_tb_top.sv */
// Self-checking bench for the request and error status block
`timescale 1ns/1ps
`default_nettype none
module ies_status_tb_top
  import ies_pkg::*;
;
  logic       clk_i;
  logic       rst_b_i;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       ant_off;
  logic       irq;
  logic       ev [0:28];
  int         error_cnt;
  int         checks;
  // Source input, register and bit it must raise
  int         s_idx [9] = '{6, 8, 1, 2, 22, 23, 24, 25, 26};
  logic [5:0] s_adr [9] = '{6'h04, 6'h04, 6'h04, 6'h04, 6'h04, 6'h04,
                            6'h04, 6'h05, 6'h05};
  logic [7:0] s_msk [9] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04,
                            8'h01, 8'h04, 8'h10};

  ies_host_model u_host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd), .rdata_i(rdata));

  ies_status u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .cmd_start_i(ev[0]), .cmd_end_i(ev[1]), .cmd_unknown_i(ev[2]),
    .host_idle_write_i(ev[3]), .crc_calculate_command_i(ev[4]),
    .card_authenticate_command_i(ev[5]), .tx_last_bit_i(ev[6]),
    .rx_last_bit_i(ev[7]), .rx_end_valid_i(ev[8]),
    .rx_startup_i(ev[9]), .receive_suppress_empty_i(ev[10]),
    .receive_crc_check_enable_i(ev[11]), .rate_106k_i(ev[12]),
    .collision_i(ev[13]), .crc_fail_i(ev[14]), .parity_fail_i(ev[15]),
    .sof_bad_i(ev[16]), .byte_count_bad_i(ev[17]),
    .fifo_not_empty_i(ev[18]), .fifo_full_i(ev[19]),
    .fifo_host_write_i(ev[20]), .fifo_write_i(ev[21]),
    .high_watermark_status_i(ev[22]), .low_watermark_status_i(ev[23]),
    .timer_zero_i(ev[24]), .crc_calc_done_i(ev[25]),
    .card_link_input_i(ev[26]), .overheat_i(ev[27]),
    .temp_clear_i(ev[28]), .antenna_off_o(ant_off), .irq_o(irq));

  always #2 clk_i = ~clk_i;

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.rd(a, d);
    checks++;
    if (d !== e) begin
      error_cnt++;
      $display("unexpected at %0t: reg %h read %h want %h", $time, a, d, e);
    end
  endtask

  task automatic chk_pin(input logic v, input logic e);
    checks++;
    if (v !== e) begin
      error_cnt++;
      $display("unexpected at %0t: pin %b want %b", $time, v, e);
    end
  endtask

  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge clk_i);
    ev[i] <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  initial begin
    repeat (5000) @(posedge clk_i);
    error_cnt++;
    $display("unexpected at %0t: run hung", $time);
    finish_test();
  end

  initial begin
    clk_i = 1'b0;
    rst_b_i = 1'b0;
    error_cnt = 0;
    checks = 0;
    foreach (ev[i]) ev[i] = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk(COM_EN_OFF, 8'h80);
    chk(AUX_EN_OFF, 8'h00);
    chk(COM_REQ_OFF, 8'h14);
    chk(AUX_REQ_OFF, 8'h00);
    chk(ERR_OFF, 8'h00);
    chk(STAT_OFF, 8'h00);
    chk(6'h3f, 8'h00);
    chk_pin(irq, 1'b1);
    done("reset");

    u_host.clr_bits(COM_REQ_OFF, 8'h7f);
    chk(COM_REQ_OFF, 8'h00);
    u_host.set_bits(COM_REQ_OFF, 8'h41);
    chk(COM_REQ_OFF, 8'h41);
    u_host.clr_bits(COM_REQ_OFF, 8'h41);
    u_host.set_bits(AUX_REQ_OFF, 8'h14);
    chk(AUX_REQ_OFF, 8'h14);
    u_host.clr_bits(AUX_REQ_OFF, 8'h14);
    chk(AUX_REQ_OFF, 8'h00);
    done("set_select");

    // The CRC calculate command stays set so its done pulse counts
    ev[4] <= 1'b1;
    for (int k = 0; k < 9; k++) begin
      pulse(s_idx[k]);
      repeat (4) @(posedge clk_i);
      chk(s_adr[k], s_msk[k]);
      u_host.clr_bits(s_adr[k], s_msk[k]);
    end
    chk(COM_REQ_OFF, 8'h00);
    ev[23] <= 1'b1;
    chk(STAT_OFF, 8'h01);
    chk(COM_REQ_OFF, 8'h04);
    ev[23] <= 1'b0;
    u_host.clr_bits(COM_REQ_OFF, 8'h04);
    chk(COM_REQ_OFF, 8'h00);
    done("sources");

    ev[1] <= 1'b1;
    ev[3] <= 1'b1;
    @(posedge clk_i);
    ev[1] <= 1'b0;
    ev[3] <= 1'b0;
    @(posedge clk_i);
    chk(COM_REQ_OFF, 8'h00);
    ev[10] <= 1'b1;
    pulse(8);
    chk(COM_REQ_OFF, 8'h00);
    ev[18] <= 1'b1;
    pulse(8);
    chk(COM_REQ_OFF, 8'h20);
    u_host.clr_bits(COM_REQ_OFF, 8'h20);
    // Timer event lands in the same cycle as the host clear
    ev[24] <= 1'b1;
    fork
      u_host.clr_bits(COM_REQ_OFF, 8'h01);
      begin
        @(posedge clk_i);
        ev[24] <= 1'b0;
      end
    join
    chk(COM_REQ_OFF, 8'h01);
    u_host.clr_bits(COM_REQ_OFF, 8'h01);
    done("refusals");

    u_host.wr(COM_EN_OFF, 8'h40);
    pulse(6);
    // The pin is launched at the edge that ends the pulse task
    @(posedge clk_i);
    chk_pin(irq, 1'b1);
    chk(STAT_OFF, 8'h10);
    u_host.wr(COM_EN_OFF, 8'hc0);
    @(posedge clk_i);
    chk_pin(irq, 1'b0);
    u_host.clr_bits(COM_REQ_OFF, 8'h40);
    @(posedge clk_i);
    chk_pin(irq, 1'b1);
    u_host.wr(AUX_EN_OFF, 8'hff);
    chk(AUX_EN_OFF, 8'h14);
    done("irq_pin");

    pulse(7);
    ev[12] <= 1'b1;
    ev[11] <= 1'b1;
    ev[5] <= 1'b1;
    pulse(13);
    chk(ERR_OFF, 8'h08);
    chk(COM_REQ_OFF, 8'h02);
    u_host.wr(ERR_OFF, 8'hff);
    chk(ERR_OFF, 8'h08);
    pulse(16);
    pulse(15);
    pulse(14);
    chk(ERR_OFF, 8'h0f);
    pulse(9);
    chk(ERR_OFF, 8'h00);
    pulse(17);
    pulse(20);
    ev[19] <= 1'b1;
    pulse(21);
    ev[27] <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk(ERR_OFF, 8'hd1);
    chk_pin(ant_off, 1'b1);
    pulse(0);
    chk(ERR_OFF, 8'h40);
    ev[12] <= 1'b0;
    ev[11] <= 1'b0;
    pulse(13);
    pulse(15);
    pulse(14);
    chk(ERR_OFF, 8'h40);
    ev[27] <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse(28);
    chk(ERR_OFF, 8'h00);
    chk_pin(ant_off, 1'b0);
    done("errors");
    finish_test();
  end
endmodule
`default_nettype wire
